// File: design/pcsst_pkg.sv
package pcsst_pkg;
  localparam int LANES    = 4;
  localparam int HDR_W    = 4;
  localparam int MM_W     = 8;
  localparam int BC_W     = 2;
  localparam int MARK_W   = 64;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int ERRBLK_W = 8;
  localparam int MMCNT_W  = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_ERRBLK = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_MMCNT  = 12'h00C;

  // control fields
  localparam int CTRL_W       = 6;
  localparam int CTRL_RX_IDLE = 0;
  localparam int CTRL_TX_IDLE = 1;
  localparam int CTRL_RX_PRI1 = 2;
  localparam int CTRL_RX_PRI2 = 3;
  localparam int CTRL_TX_PRI1 = 4;
  localparam int CTRL_TX_PRI2 = 5;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

  // status fields
  localparam int ST_LOCK_LSB   = 0;
  localparam int ST_ALIGNED    = 4;
  localparam int ST_HIBER      = 5;
  localparam int ST_LFAULT     = 6;
  localparam int ST_FIFOERR    = 7;
  localparam int ST_RXMODE_LSB = 8;
  localparam int ST_TXMODE_LSB = 10;

  localparam logic [MARK_W-1:0] MARK_RESET = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_PRI1,
    MODE_PRI2,
    MODE_IDLE
  } pcsst_mode_type;

  typedef enum logic [2:0] {
    REG_CTRL,
    REG_STATUS,
    REG_ERRBLK,
    REG_MMCNT,
    REG_NONE
  } pcsst_reg_type;
endpackage

// File: design/pcsst_lane_if.sv
`timescale 1ns/1ps
// per-lane raw events in, registered lane status out
interface pcsst_lane_if;
  logic                       lock_raw;
  logic [pcsst_pkg::HDR_W-1:0] hdr_err_raw;
  logic                       hdr_err_raw_vld;
  logic                       sreset;
  logic                       lock;
  logic [pcsst_pkg::HDR_W-1:0] err_inc;
  logic                       err_vld;

  modport stage (
    input  lock_raw, hdr_err_raw, hdr_err_raw_vld, sreset,
    output lock, err_inc, err_vld
  );
  modport core (
    output lock_raw, hdr_err_raw, hdr_err_raw_vld, sreset,
    input  lock, err_inc, err_vld
  );
endinterface

// File: design/pcsst_lane_stage.sv
`timescale 1ns/1ps
module pcsst_lane_stage (
  input wire logic     sys_clk, // core clock
  input wire logic     rst,     // async reset, active high
  pcsst_lane_if.stage  lif      // lane raw events and status
);
  logic                        next_lock;
  logic [pcsst_pkg::HDR_W-1:0] next_inc;
  logic                        next_vld;

  // lock follows the lane, increments pass for one cycle when valid
  always_comb begin
    next_lock = lif.lock_raw & ~lif.sreset;
    next_inc  = '0;
    next_vld  = 1'b0;
    if (!lif.sreset && lif.hdr_err_raw_vld) begin
      next_inc = lif.hdr_err_raw;
      next_vld = 1'b1;
    end
  end

  // lane status registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lif.lock    <= 1'b0;
      lif.err_inc <= '0;
      lif.err_vld <= 1'b0;
    end else begin
      lif.lock    <= next_lock;
      lif.err_inc <= next_inc;
      lif.err_vld <= next_vld;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  lane_lock_a: assert property (
    lif.lock_raw && !lif.sreset |=> lif.lock)
    else $error("lane lock not raised after raw lock");
  hdr_inc_a: assert property (
    lif.hdr_err_raw_vld && !lif.sreset
      |=> lif.err_vld && lif.err_inc == $past(lif.hdr_err_raw))
    else $error("sync header increment lost");
  hdr_vld_a: assert property (
    !lif.err_vld |-> lif.err_inc == '0)
    else $error("header increment nonzero without valid");
  lane_rst_a: assert property (
    lif.sreset |=> !lif.lock && !lif.err_vld)
    else $error("lane status live during receive reset");
  lane_err_c: cover property (lif.err_vld && lif.err_inc != '0);
endmodule

// File: design/pcsst_core.sv
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pcsst_core (
  input  wire logic                          sys_clk,   // core clock
  input  wire logic                          rst,       // async reset
  input  wire logic                          psel,      // apb select
  input  wire logic                          penable,   // apb enable
  input  wire logic                          pwrite,    // apb direction
  input  wire logic [pcsst_pkg::ADDR_W-1:0]  paddr,     // apb address
  input  wire logic [pcsst_pkg::DATA_W-1:0]  pwdata,    // apb write data
  output logic      [pcsst_pkg::DATA_W-1:0]  prdata,    // apb read data
  output logic                               pready,    // apb ready
  output logic                               pslverr,   // apb error
  input  wire logic                          rx_reset,  // rx sync reset
  input  wire logic                          tx_reset,  // tx sync reset
  input  wire logic [pcsst_pkg::MARK_W-1:0]  tx_lane2_alignment_marker, // in
  input  wire logic [pcsst_pkg::MARK_W-1:0]  tx_lane3_alignment_marker, // in
  input  wire logic [pcsst_pkg::LANES-1:0]   rx_lock_raw,     // lane lock
  input  wire logic [pcsst_pkg::LANES-1:0]   rx_deskew_raw,   // lane deskew
  input  wire logic                          rx_ber_high_raw, // ber high
  input  wire logic                          rx_decoder_init, // in init
  input  wire logic                          rx_fifo_over,    // overflow
  input  wire logic                          rx_fifo_under,   // underflow
  input  wire logic [pcsst_pkg::BC_W-1:0]    rx_bad_code_raw, // bad blocks
  input  wire logic                          rx_bad_code_rvld,// its valid
  input  wire logic [pcsst_pkg::MM_W-1:0]    rx_mismatch_raw, // mismatches
  input  wire logic                          rx_mismatch_rvld,// its valid
  input  wire logic [pcsst_pkg::LANES-1:0][pcsst_pkg::HDR_W-1:0]
                                             rx_hdr_err_raw,  // per lane
  input  wire logic [pcsst_pkg::LANES-1:0]   rx_hdr_err_rvld, // per lane
  output logic      [pcsst_pkg::MARK_W-1:0]  tx_lane2_marker, // inserted
  output logic      [pcsst_pkg::MARK_W-1:0]  tx_lane3_marker, // inserted
  output logic                               tx_idle_gen_en,  // tx idle
  output logic                               rx_idle_check_en,// rx check
  output logic                               rx_comp_fifo_error, // sticky
  output logic                               rx_local_fault,  // level
  output logic                               rx_excess_bit_error_rate, // lvl
  output logic      [pcsst_pkg::LANES-1:0]   rx_block_lock,   // per lane
  output logic                               rx_all_lanes_aligned, // level
  output logic      [pcsst_pkg::MM_W-1:0]    rx_mismatch_inc, // pulse
  output logic                               rx_mismatch_valid, // strobe
  output logic      [pcsst_pkg::BC_W-1:0]    rx_code_viol_inc,  // pulse
  output logic                               rx_code_viol_valid,// strobe
  output logic      [pcsst_pkg::LANES-1:0][pcsst_pkg::HDR_W-1:0]
                                             rx_sync_hdr_inc, // per lane
  output logic      [pcsst_pkg::LANES-1:0]   rx_sync_hdr_valid // per lane
);
  localparam int AW = pcsst_pkg::ADDR_W;
  localparam int DW = pcsst_pkg::DATA_W;
  localparam int EW = pcsst_pkg::ERRBLK_W;
  localparam int CW = pcsst_pkg::MMCNT_W;

  logic [pcsst_pkg::CTRL_W-1:0] ctrl;
  logic [pcsst_pkg::CTRL_W-1:0] next_ctrl;
  logic [DW-1:0]                next_prdata;
  logic                         next_pready;
  logic                         next_pslverr;
  logic                         next_tx_idle;
  logic                         next_rx_idle;
  logic [EW-1:0]                errblk_cnt;
  logic [EW-1:0]                next_errblk_cnt;
  logic [CW-1:0]                mm_cnt;
  logic [CW-1:0]                next_mm_cnt;
  logic [pcsst_pkg::MARK_W-1:0] next_lane2_marker;
  logic [pcsst_pkg::MARK_W-1:0] next_lane3_marker;
  logic                         next_fifo_err;
  logic                         next_lfault;
  logic                         next_hiber;
  logic                         next_aligned;
  logic [pcsst_pkg::MM_W-1:0]   next_mm_inc;
  logic                         next_mm_vld;
  logic [pcsst_pkg::BC_W-1:0]   next_bc_inc;
  logic                         next_bc_vld;
  logic                         setup;
  logic                         wr_done;
  pcsst_pkg::pcsst_reg_type     sel;
  pcsst_pkg::pcsst_mode_type    rx_mode;
  pcsst_pkg::pcsst_mode_type    tx_mode;
  logic [DW-1:0]                status_word;

  // higher-priority test modes win over the idle pattern
  function automatic pcsst_pkg::pcsst_mode_type resolve_mode(
    input logic pri1, input logic pri2, input logic idle);
    if (pri1)
      return pcsst_pkg::MODE_PRI1;
    else if (pri2)
      return pcsst_pkg::MODE_PRI2;
    else if (idle)
      return pcsst_pkg::MODE_IDLE;
    return pcsst_pkg::MODE_OFF;
  endfunction

  // register select from a bus address
  function automatic pcsst_pkg::pcsst_reg_type decode_reg(
    input logic [AW-1:0] a);
    case (a)
      pcsst_pkg::OFF_CTRL:   return pcsst_pkg::REG_CTRL;
      pcsst_pkg::OFF_STATUS: return pcsst_pkg::REG_STATUS;
      pcsst_pkg::OFF_ERRBLK: return pcsst_pkg::REG_ERRBLK;
      pcsst_pkg::OFF_MMCNT:  return pcsst_pkg::REG_MMCNT;
      default:               return pcsst_pkg::REG_NONE;
    endcase
  endfunction

  // per-lane stages
  genvar g;
  generate
    for (g = 0; g < pcsst_pkg::LANES; g++) begin : gen_lane
      pcsst_lane_if lif ();
      assign lif.lock_raw        = rx_lock_raw[g];
      assign lif.hdr_err_raw     = rx_hdr_err_raw[g];
      assign lif.hdr_err_raw_vld = rx_hdr_err_rvld[g];
      assign lif.sreset          = rx_reset;
      assign rx_block_lock[g]     = lif.lock;
      assign rx_sync_hdr_inc[g]   = lif.err_inc;
      assign rx_sync_hdr_valid[g] = lif.err_vld;
      pcsst_lane_stage u_stage (
        .sys_clk (sys_clk),
        .rst     (rst),
        .lif     (lif)
      );
    end
  endgenerate

  // bus decode and mode resolution
  assign setup   = psel & ~penable;
  assign wr_done = psel & penable & pready & pwrite;
  assign sel     = decode_reg(paddr);
  assign rx_mode = resolve_mode(ctrl[pcsst_pkg::CTRL_RX_PRI1],
                                ctrl[pcsst_pkg::CTRL_RX_PRI2],
                                ctrl[pcsst_pkg::CTRL_RX_IDLE]);
  assign tx_mode = resolve_mode(ctrl[pcsst_pkg::CTRL_TX_PRI1],
                                ctrl[pcsst_pkg::CTRL_TX_PRI2],
                                ctrl[pcsst_pkg::CTRL_TX_IDLE]);

  // status word assembly
  always_comb begin
    status_word = '0;
    status_word[pcsst_pkg::ST_LOCK_LSB +: pcsst_pkg::LANES] = rx_block_lock;
    status_word[pcsst_pkg::ST_ALIGNED]    = rx_all_lanes_aligned;
    status_word[pcsst_pkg::ST_HIBER]      = rx_excess_bit_error_rate;
    status_word[pcsst_pkg::ST_LFAULT]     = rx_local_fault;
    status_word[pcsst_pkg::ST_FIFOERR]    = rx_comp_fifo_error;
    status_word[pcsst_pkg::ST_RXMODE_LSB +: 2] = rx_mode;
    status_word[pcsst_pkg::ST_TXMODE_LSB +: 2] = tx_mode;
  end

  // bus slave and control next values
  always_comb begin
    next_ctrl    = ctrl;
    next_pready  = setup;
    next_pslverr = setup && sel == pcsst_pkg::REG_NONE;
    next_prdata  = '0;
    if (wr_done && sel == pcsst_pkg::REG_CTRL) begin
      next_ctrl = pwdata[pcsst_pkg::CTRL_W-1:0];
    end
    if (setup && !pwrite) begin
      unique case (sel)
        pcsst_pkg::REG_CTRL:   next_prdata = DW'(ctrl);
        pcsst_pkg::REG_STATUS: next_prdata = status_word;
        pcsst_pkg::REG_ERRBLK: next_prdata = DW'(errblk_cnt);
        pcsst_pkg::REG_MMCNT:  next_prdata = DW'(mm_cnt);
        default:               next_prdata = '0;
      endcase
    end
    next_rx_idle = rx_mode == pcsst_pkg::MODE_IDLE;
    next_tx_idle = tx_mode == pcsst_pkg::MODE_IDLE;
  end

  // bus slave and control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl             <= pcsst_pkg::CTRL_RESET;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      prdata           <= '0;
      rx_idle_check_en <= 1'b0;
      tx_idle_gen_en   <= 1'b0;
    end else begin
      ctrl             <= next_ctrl;
      pready           <= next_pready;
      pslverr          <= next_pslverr;
      prdata           <= next_prdata;
      rx_idle_check_en <= next_rx_idle;
      tx_idle_gen_en   <= next_tx_idle;
    end
  end

  // markers are sampled only while the tx reset holds them still
  always_comb begin
    next_lane2_marker = tx_lane2_marker;
    next_lane3_marker = tx_lane3_marker;
    if (tx_reset) begin
      next_lane2_marker = tx_lane2_alignment_marker;
      next_lane3_marker = tx_lane3_alignment_marker;
    end
  end

  // inserted marker registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_lane2_marker <= pcsst_pkg::MARK_RESET;
      tx_lane3_marker <= pcsst_pkg::MARK_RESET;
    end else begin
      tx_lane2_marker <= next_lane2_marker;
      tx_lane3_marker <= next_lane3_marker;
    end
  end

  // receive status and increments
  always_comb begin
    next_aligned  = !rx_reset && (&rx_lock_raw)
                    && (&rx_deskew_raw);
    next_lfault   = rx_decoder_init || !next_aligned;
    next_hiber    = rx_ber_high_raw;
    next_fifo_err = !rx_reset && (rx_comp_fifo_error
                    || rx_fifo_over || rx_fifo_under);
    next_bc_inc   = '0;
    next_bc_vld   = 1'b0;
    next_mm_inc   = '0;
    next_mm_vld   = 1'b0;
    if (!rx_reset && rx_bad_code_rvld) begin
      next_bc_inc = rx_bad_code_raw;
      next_bc_vld = 1'b1;
    end
    if (!rx_reset && rx_mismatch_rvld && next_rx_idle) begin
      next_mm_inc = rx_mismatch_raw;
      next_mm_vld = 1'b1;
    end
  end

  // receive status registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_all_lanes_aligned     <= 1'b0;
      rx_local_fault           <= 1'b1;
      rx_excess_bit_error_rate <= 1'b0;
      rx_comp_fifo_error       <= 1'b0;
      rx_code_viol_inc         <= '0;
      rx_code_viol_valid       <= 1'b0;
      rx_mismatch_inc          <= '0;
      rx_mismatch_valid        <= 1'b0;
    end else begin
      rx_all_lanes_aligned     <= next_aligned;
      rx_local_fault           <= next_lfault;
      rx_excess_bit_error_rate <= next_hiber;
      rx_comp_fifo_error       <= next_fifo_err;
      rx_code_viol_inc         <= next_bc_inc;
      rx_code_viol_valid       <= next_bc_vld;
      rx_mismatch_inc          <= next_mm_inc;
      rx_mismatch_valid        <= next_mm_vld;
    end
  end

  // saturating counters; a bus write clears before a same-cycle increment is added, rx reset wins over both
  always_comb begin
    logic [EW:0] eb_sum;
    logic [CW:0] mm_sum;
    eb_sum = '0;
    mm_sum = '0;
    next_errblk_cnt = errblk_cnt;
    next_mm_cnt     = mm_cnt;
    if (wr_done && sel == pcsst_pkg::REG_ERRBLK)
      next_errblk_cnt = '0;
    if (wr_done && sel == pcsst_pkg::REG_MMCNT)
      next_mm_cnt = '0;
    if (rx_code_viol_valid) begin
      eb_sum = {1'b0, next_errblk_cnt} + (EW+1)'(rx_code_viol_inc);
      next_errblk_cnt = eb_sum[EW] ? '1 : eb_sum[EW-1:0];
    end
    if (rx_mismatch_valid) begin
      mm_sum = {1'b0, next_mm_cnt} + (CW+1)'(rx_mismatch_inc);
      next_mm_cnt = mm_sum[CW] ? '1 : mm_sum[CW-1:0];
    end
    if (rx_reset) begin
      next_errblk_cnt = '0;
      next_mm_cnt     = '0;
    end
  end

  // counter registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      errblk_cnt <= '0;
      mm_cnt     <= '0;
    end else begin
      errblk_cnt <= next_errblk_cnt;
      mm_cnt     <= next_mm_cnt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  marker_hold_a: assert property (
    !tx_reset && !$past(tx_reset) |-> $stable(tx_lane2_marker)
      && $stable(tx_lane3_marker))
    else $error("marker changed outside tx reset");
  rx_prec_a: assert property (
    rx_idle_check_en |-> $past(ctrl[pcsst_pkg::CTRL_RX_IDLE]
      && !ctrl[pcsst_pkg::CTRL_RX_PRI1]
      && !ctrl[pcsst_pkg::CTRL_RX_PRI2]))
    else $error("rx idle check active against precedence");
  tx_prec_a: assert property (
    $past(ctrl[pcsst_pkg::CTRL_TX_IDLE]
      && !ctrl[pcsst_pkg::CTRL_TX_PRI1]
      && !ctrl[pcsst_pkg::CTRL_TX_PRI2]) == tx_idle_gen_en)
    else $error("tx idle generation wrong");
  fifo_err_a: assert property (
    (rx_fifo_over || rx_fifo_under) && !rx_reset
      |=> rx_comp_fifo_error)
    else $error("fifo error not raised");
  fifo_hold_a: assert property (
    rx_comp_fifo_error && !rx_reset |=> rx_comp_fifo_error)
    else $error("fifo error dropped before rx reset");
  init_fault_a: assert property (
    rx_decoder_init |=> rx_local_fault)
    else $error("local fault low in decoder init");
  hiber_level_a: assert property (
    rx_ber_high_raw ##1 rx_ber_high_raw |-> rx_excess_bit_error_rate)
    else $error("high error rate not shown");
  mm_gate_a: assert property (
    rx_mismatch_valid |-> rx_idle_check_en)
    else $error("mismatch valid without idle check");
  mm_pulse_a: assert property (
    rx_mismatch_rvld && !rx_reset && next_rx_idle
      |=> rx_mismatch_valid && rx_mismatch_inc == $past(rx_mismatch_raw))
    else $error("mismatch increment lost");
  mm_valid_a: assert property (
    !rx_mismatch_valid |-> rx_mismatch_inc == '0)
    else $error("mismatch increment without valid");
  bad_code_a: assert property (
    rx_bad_code_rvld && !rx_reset
      |=> rx_code_viol_valid && rx_code_viol_inc == $past(rx_bad_code_raw))
    else $error("code violation increment lost");
  bc_valid_a: assert property (
    !rx_code_viol_valid |-> rx_code_viol_inc == '0)
    else $error("code violation increment without valid");
  aligned_lock_a: assert property (
    rx_all_lanes_aligned |-> &rx_block_lock)
    else $error("aligned without full block lock");
  unaligned_fault_a: assert property (
    !rx_all_lanes_aligned |-> rx_local_fault)
    else $error("no local fault while unaligned");
  rx_reset_zero_a: assert property (
    rx_reset |=> !rx_mismatch_valid && !rx_code_viol_valid
      && rx_block_lock == '0 && !rx_all_lanes_aligned)
    else $error("status live during rx reset");

  aligned_c: cover property (!rx_all_lanes_aligned ##1 rx_all_lanes_aligned);
  mm_c: cover property (rx_mismatch_valid && rx_mismatch_inc != '0);
  fifo_c: cover property (rx_comp_fifo_error ##1 rx_reset);
  tx_idle_c: cover property (tx_idle_gen_en && rx_idle_check_en);
endmodule

// File: dv/pcsst_user_model.sv
`timescale 1ns/1ps
// user-side statistics collector; resets the rx port after a fifo error
module pcsst_user_model (
  input  wire logic       sys_clk,  // core clock
  input  wire logic       rst,      // async reset
  input  wire logic       fifo_err, // fifo error level
  input  wire logic [1:0] viol_inc, // code violation increment
  input  wire logic       viol_vld, // its strobe
  output logic            rx_reset, // port reset, synchronous
  output logic [7:0]      tally     // errored block total
);
  // reset request follows the error, so it drops once the error clears
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_reset <= 1'b0;
      tally    <= 8'h00;
    end else begin
      rx_reset <= fifo_err;
      if (viol_vld) begin
        tally <= tally + {6'h00, viol_inc};
      end
    end
  end
endmodule

// File: dv/pcs_rx_lane_status_test_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module pcs_rx_lane_status_test_tb;
  typedef struct {
    logic [3:0] lk, dk;
    logic       ini, ber, al, lf;
  } pcsst_row_type;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, rx_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e, tx_reset, rx_ber_high_raw, rx_decoder_init, rx_fifo_over;
  logic rx_fifo_under, rx_bad_code_rvld, rx_mismatch_rvld;
  logic [63:0] tx_lane2_alignment_marker, tx_lane3_alignment_marker;
  logic [63:0] tx_lane2_marker, tx_lane3_marker;
  logic [3:0] rx_lock_raw, rx_deskew_raw, rx_hdr_err_rvld, rx_block_lock;
  logic [1:0] rx_bad_code_raw, rx_code_viol_inc;
  logic [7:0] rx_mismatch_raw, rx_mismatch_inc, tally;
  logic [3:0][3:0] rx_hdr_err_raw, rx_sync_hdr_inc;
  logic [3:0] rx_sync_hdr_valid;
  logic tx_idle_gen_en, rx_idle_check_en, rx_comp_fifo_error;
  logic rx_local_fault, rx_excess_bit_error_rate, rx_all_lanes_aligned;
  logic rx_mismatch_valid, rx_code_viol_valid;
  int fail_count, comparisons, cycles;
  pcsst_row_type rows [5] = '{'{4'h0, 4'h0, 0, 1, 0, 1},
    '{4'hF, 4'h7, 0, 0, 0, 1}, '{4'h5, 4'hF, 0, 1, 0, 1},
    '{4'hF, 4'hF, 1, 0, 1, 1}, '{4'hF, 4'hF, 0, 0, 1, 0}};

  pcsst_core u_pcsst_core (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_reset, .tx_reset,
    .tx_lane2_alignment_marker, .tx_lane3_alignment_marker, .rx_lock_raw,
    .rx_deskew_raw, .rx_ber_high_raw, .rx_decoder_init, .rx_fifo_over,
    .rx_fifo_under, .rx_bad_code_raw, .rx_bad_code_rvld, .rx_mismatch_raw,
    .rx_mismatch_rvld, .rx_hdr_err_raw, .rx_hdr_err_rvld, .tx_lane2_marker,
    .tx_lane3_marker, .tx_idle_gen_en, .rx_idle_check_en, .rx_comp_fifo_error,
    .rx_local_fault, .rx_excess_bit_error_rate, .rx_block_lock,
    .rx_all_lanes_aligned, .rx_mismatch_inc, .rx_mismatch_valid,
    .rx_code_viol_inc, .rx_code_viol_valid, .rx_sync_hdr_inc,
    .rx_sync_hdr_valid);
  pcsst_user_model u_pcsst_user_model (.sys_clk(sys_clk), .rst(rst),
    .fifo_err(rx_comp_fifo_error), .viol_inc(rx_code_viol_inc),
    .viol_vld(rx_code_viol_valid), .rx_reset(rx_reset), .tally(tally));

  // clock and hang guard
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  task cyc;
    @(posedge sys_clk);
  endtask

  // one apb transfer, waits for pready at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task stop_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    {sys_clk, psel, penable, pwrite, paddr, pwdata, tx_reset} = '0;
    {rx_ber_high_raw, rx_decoder_init, rx_fifo_over, rx_fifo_under} = '0;
    {rx_bad_code_rvld, rx_mismatch_rvld, rx_bad_code_raw} = '0;
    {rx_mismatch_raw, rx_lock_raw, rx_deskew_raw, rx_hdr_err_rvld} = '0;
    {rx_hdr_err_raw, tx_lane2_alignment_marker} = '0;
    tx_lane3_alignment_marker = '0;
    rst = 1'b1;
    repeat (3) cyc;
    #1;
    `CHK(rx_local_fault, 1'b1)
    cyc;
    rst <= 1'b0;
    foreach (rows[i]) begin
      cyc;
      rx_lock_raw <= rows[i].lk;
      rx_deskew_raw <= rows[i].dk;
      rx_decoder_init <= rows[i].ini;
      rx_ber_high_raw <= rows[i].ber;
      cyc;
      #1;
      `CHK(rx_block_lock, rows[i].lk)
      `CHK(rx_all_lanes_aligned, rows[i].al)
      `CHK(rx_local_fault, rows[i].lf)
      `CHK(rx_excess_bit_error_rate, rows[i].ber)
    end
    // mismatch dropped while idle check is off, then passed when on
    for (int k = 0; k < 2; k++) begin
      cyc;
      rx_mismatch_raw <= 8'h05;
      rx_mismatch_rvld <= 1'b1;
      cyc;
      rx_mismatch_raw <= 8'h00;
      rx_mismatch_rvld <= 1'b0;
      #1;
      `CHK(rx_mismatch_inc, k ? 8'h05 : 8'h00)
      `CHK(rx_mismatch_valid, k[0])
      `CHK({rx_idle_check_en, tx_idle_gen_en}, {2{k[0]}})
      if (k == 0) apb(1'b1, 12'h000, 32'h0000_0003);
    end
    cyc;
    #1;
    `CHK(rx_mismatch_valid, 1'b0)
    apb(1'b1, 12'h000, 32'h0000_0005);
    cyc;
    #1;
    `CHK(rx_idle_check_en, 1'b0)
    // code violations and their accumulation
    cyc;
    rx_bad_code_raw <= 2'h3;
    rx_bad_code_rvld <= 1'b1;
    cyc;
    rx_bad_code_rvld <= 1'b0;
    #1;
    `CHK({rx_code_viol_inc, rx_code_viol_valid}, 3'h7)
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK(r, 32'h0000_0003)
    `CHK(tally, 8'h03)
    apb(1'b1, 12'h008, 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    `CHK(r, 32'h0000_0000)
    // sync header errors lane by lane
    for (int l = 0; l < 4; l++) begin
      cyc;
      rx_hdr_err_raw[l] <= 4'(l + 1);
      rx_hdr_err_rvld <= 4'(1 << l);
      cyc;
      rx_hdr_err_raw <= '0;
      rx_hdr_err_rvld <= 4'h0;
      #1;
      `CHK(rx_sync_hdr_inc[l], 4'(l + 1))
      `CHK(rx_sync_hdr_valid, 4'(1 << l))
    end
    // markers loaded under tx reset
    cyc;
    tx_reset <= 1'b1;
    tx_lane2_alignment_marker <= 64'h0123_4567_89AB_CDEF;
    tx_lane3_alignment_marker <= 64'hFEDC_BA98_7654_3210;
    cyc;
    tx_reset <= 1'b0;
    cyc;
    #1;
    `CHK(tx_lane2_marker, 64'h0123_4567_89AB_CDEF)
    `CHK(tx_lane3_marker, 64'hFEDC_BA98_7654_3210)
    apb(1'b0, 12'h00C, 32'h0000_0000);
    `CHK(r, 32'h0000_0005)
    apb(1'b0, 12'h004, 32'h0000_0000);
    `CHK(r, 32'h0000_011F)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK({e, r}, 33'h1_0000_0000)
    // fifo overflow, then underflow; each time the partner resets the port
    for (int f = 0; f < 2; f++) begin
      cyc;
      rx_fifo_over <= f == 0;
      rx_fifo_under <= f == 1;
      cyc;
      rx_fifo_over <= 1'b0;
      rx_fifo_under <= 1'b0;
      #1;
      `CHK(rx_comp_fifo_error, 1'b1)
      repeat (2) cyc;
      #1;
      `CHK(rx_comp_fifo_error, 1'b0)
      `CHK({rx_block_lock, rx_all_lanes_aligned}, 5'h00)
    end
    stop_test();
  end
endmodule
